// ===== iobd_pkg.sv
// Purpose: shared constants and types for the remote I/O bus diagnostic block
// Assumes: 10 MHz controller clock, 16-bit register words
// Notes:   register offsets are word indices on the plain register port
package iobd_pkg;
  // clock and timestamp resolution
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int TIME_RES_MS = 100;
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000) * TIME_RES_MS;

  // register offsets
  localparam logic [7:0] A_FAULT_REF  = 8'h02;
  localparam logic [7:0] A_FAULT_CKT  = 8'h03;
  localparam logic [7:0] A_FAULT_STS  = 8'h04;
  localparam logic [7:0] A_FAULT_CLS  = 8'h05;
  localparam logic [7:0] A_FAULT_DET  = 8'h06;
  localparam logic [7:0] A_FAULT_KIND = 8'h07;
  localparam logic [7:0] A_FAULT_SEC  = 8'h08;
  localparam logic [7:0] A_FAULT_HR   = 8'h09;
  localparam logic [7:0] A_FAULT_DAY  = 8'h0A;
  localparam logic [7:0] A_CMD        = 8'h10;
  localparam logic [7:0] A_CMD_REF    = 8'h11;
  localparam logic [7:0] A_STATUS     = 8'h12;
  localparam logic [7:0] A_CLK_SEC    = 8'h18;
  localparam logic [7:0] A_CLK_HR     = 8'h19;
  localparam logic [7:0] A_CLK_DAY    = 8'h1A;
  localparam logic [7:0] A_PSTAT      = 8'h20;

  // command word fields
  localparam int CMD_DIS_OUT = 0;
  localparam int CMD_CLR_ALL = 1;
  localparam int CMD_CLR_CKT = 2;
  localparam int CMD_PTEST   = 3;
  localparam int CMD_CKT_IN  = 8;

  // fault class one-hot positions within the class byte
  localparam int CLS_CIRCUIT = 2;
  localparam int CLS_LOST    = 3;
  localparam int CLS_W       = 7;

  // record field positions
  localparam int W2_IN_BIT  = 10;
  localparam int W2_OUT_BIT = 11;
  localparam int W7_DISC    = 0;
  localparam int W7_ANA     = 1;
  localparam int DISC_DET_W = 6;

  // block type codes
  localparam logic [3:0] BLK_DISCRETE = 4'h1;
  localparam logic [3:0] BLK_ANALOG   = 4'h2;

  // analog circuits and status pattern
  localparam int ANA_STRIDE  = 6;
  localparam int ANA_ALARMS  = 5;
  localparam int ANA_CKTS    = 6;
  localparam int ANA_OUT_OFS = 4;

  localparam logic [4:0] LAST_DEV = 5'h1F;

  // master clock wrap limits
  localparam logic [7:0] TENTHS_MAX = 8'h09;
  localparam logic [7:0] SEC_MAX    = 8'h3B;
  localparam logic [7:0] HR_MAX     = 8'h17;
  localparam logic [7:0] DAY_MAX    = 8'h63;

  typedef enum {T_IDLE, T_SCAN, T_WAIT} ptest_state_t;
endpackage

// ===== time_if.sv
`timescale 1ns/1ps
// Purpose: master clock fields and the software time load path
// Assumes: single clock domain
// Notes:   set_sel picks the word pair that set_data loads
interface time_if;
  logic [7:0]  tenths, sec, min, hr, days, hund;
  logic        set_en;
  logic [1:0]  set_sel;
  logic [15:0] set_data;
  modport src  (output tenths, sec, min, hr, days, hund, input set_en, set_sel, set_data);
  modport user (input tenths, sec, min, hr, days, hund, output set_en, set_sel, set_data);
endinterface

// ===== master_clock.sv
`timescale 1ns/1ps
// Purpose: free-running day clock at 100 ms resolution
// Assumes: power_ok_i low while supply is lost
// Notes:   counts in run and stop mode alike; software sets real time
module master_clock #(
  parameter int TICK = iobd_pkg::TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic power_ok_i,
  time_if.src       tm
);
  import iobd_pkg::*;

  logic [31:0] div;
  logic        tick;

  // divider freezes with power so the held value resumes cleanly
  always_ff @(posedge clk_i) begin
    if (reset_i || !power_ok_i) begin
      tick <= 1'b0;
      if (reset_i) div <= 32'h0;
    end else if (div == 32'(TICK - 1)) begin
      div  <= 32'h0;
      tick <= 1'b1;
    end else begin
      div  <= div + 32'h1;
      tick <= 1'b0;
    end
  end

  // cascaded counters; a software load takes priority over a tick
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tm.tenths <= 8'h0; tm.sec <= 8'h0; tm.min <= 8'h0;
      tm.hr <= 8'h0; tm.days <= 8'h0; tm.hund <= 8'h0;
    end else if (tm.set_en) begin
      case (tm.set_sel)
        2'h0: {tm.sec, tm.tenths} <= tm.set_data;
        2'h1: {tm.hr, tm.min}     <= tm.set_data;
        default: {tm.hund, tm.days} <= tm.set_data;
      endcase
    end else if (tick) begin // R7 R8
      tm.tenths <= (tm.tenths == TENTHS_MAX) ? 8'h0 : tm.tenths + 8'h1;
      if (tm.tenths == TENTHS_MAX) begin
        tm.sec <= (tm.sec == SEC_MAX) ? 8'h0 : tm.sec + 8'h1;
        if (tm.sec == SEC_MAX) begin
          tm.min <= (tm.min == SEC_MAX) ? 8'h0 : tm.min + 8'h1;
          if (tm.min == SEC_MAX) begin
            tm.hr <= (tm.hr == HR_MAX) ? 8'h0 : tm.hr + 8'h1;
            if (tm.hr == HR_MAX) begin
              tm.days <= (tm.days == DAY_MAX) ? 8'h0 : tm.days + 8'h1;
              if (tm.days == DAY_MAX) begin
                tm.hund <= (tm.hund == DAY_MAX) ? 8'h0 : tm.hund + 8'h1;
              end
            end
          end
        end
      end
    end
  end
endmodule // master_clock

// ===== io_bus_fault_diag.sv
`timescale 1ns/1ps
// Purpose: fault record formatting, command decode, pulse test and point map
// Assumes: bus controller reports a fault as a one-cycle fault_valid_i
// Notes:   register port is word addressed, read data one cycle later
// Notes on behaviour
// R1 - word 3 high byte: circuit number, else zero
// R2 - words 4 and 5 copy status bytes 4-6
// R3 - word 5 high byte one-hot class, bit15 zero
// R4 - word 6 low byte block type code
// R5 - word 6 high byte discrete circuit detail
// R6 - word 7 discrete/analog kind, upper zero
// R7 - words 8-10 timestamp at 100 ms
// R8 - clock runs always, freezes on power loss
// R9 - command bytes share base, bytes 5-6 reserved
// R10 - command bit 0 stops output data
// R11 - blocks hold outputs, fail after 500 ms
// R12 - bit 1 clears all faults per transition
// R13 - bit 2 clears one circuit per scan
// R14 - analog circuits addressed by reference offset
// R15 - user reloads reference and re-raises bit 2
// R16 - bit 3 starts discrete output pulse test
// R17 - test walks devices 0 to 31
// R18 - active drops at end, restarts if held
// R19 - user pulses test bit, every 5 minutes
// R20 - byte 2 bit 0 gives circuit type
// R21 - point bit set on circuit or block fault
// R22 - point bits sticky until software writes
// R23 - analog input status 24-bit pattern
// R24 - test active from command to completion
// R25 - word 2 bits 10/11 input/output circuit
// R26 - whole record written in one cycle
module io_bus_fault_diag #(
  parameter int NPTS = 64,
  parameter int TICK = iobd_pkg::TICK_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic [15:0]              reg_wdata_i,
  input  wire logic                     reg_we_i,
  input  wire logic                     reg_re_i,
  output logic      [15:0]              reg_rdata_o,
  input  wire logic                     power_ok_i,
  input  wire logic                     scan_tick_i,
  input  wire logic                     fault_valid_i,
  input  wire logic [iobd_pkg::CLS_W-1:0] fault_class_i,
  input  wire logic [3:0]               fault_ckt_num_i,
  input  wire logic [9:0]               fault_ref_i,
  input  wire logic [7:0]               fault_blk_cnt_i,
  input  wire logic                     fault_in_ckt_i,
  input  wire logic                     fault_out_ckt_i,
  input  wire logic [3:0]               fault_blk_type_i,
  input  wire logic [7:0]               status4_i,
  input  wire logic [7:0]               status5_i,
  input  wire logic [7:0]               status6_i,
  input  wire logic [9:0]               sel_blk_start_i,
  input  wire logic [31:0]              test_eligible_i,
  input  wire logic                     test_done_i,
  output logic                          send_enable_o,
  output logic                          clear_all_o,
  output logic                          clear_circuit_o,
  output logic      [9:0]               clear_ref_o,
  output logic                          circuit_is_input_o,
  output logic                          analog_sel_valid_o,
  output logic      [2:0]               analog_sel_o,
  output logic                          test_active_o,
  output logic                          test_start_o,
  output logic      [4:0]               test_dev_o,
  output logic      [NPTS-1:0]          point_status_o
);
  import iobd_pkg::*;

  localparam int NWORDS = NPTS / 16;

  time_if tm ();

  logic [15:0]  fault_reference_word, fault_circuit_number_word, fault_status_copy_word;
  logic [15:0]  fault_class_word, fault_detail_word, fault_circuit_kind_word;
  logic [15:0]  fault_time_seconds_word, fault_time_hours_word, fault_time_days_word;
  logic [15:0]  cmd, cmd_ref;
  logic         prev_clr_all, prev_clr_ckt, clr_ckt_armed, test_req;
  ptest_state_t tstate;
  logic         is_ckt, is_disc, is_ana;
  logic [NPTS-1:0] set_mask;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  master_clock #(.TICK(TICK)) u_clock (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .power_ok_i (power_ok_i),
    .tm         (tm)
  );

  // mask of points a fault marks; analog inputs use a six-bit stride per input
  function automatic logic [NPTS-1:0] point_mask(input logic [9:0] rf, input logic [7:0] cnt,
                                                 input logic whole, input logic ana,
                                                 input logic [3:0] ckt, input logic [7:0] det);
    logic [NPTS-1:0] m;
    int              base;
    m    = '0;
    base = int'(rf) - 1;
    for (int i = 0; i < NPTS; i++) begin
      if (whole) begin
        m[i] = (i >= base) && (i < base + int'(cnt));
      end else if (ana) begin
        for (int j = 0; j < ANA_ALARMS; j++) begin
          if (i == base + int'(ckt) * ANA_STRIDE + j) m[i] = det[j]; // R23
        end
      end else begin
        m[i] = (i == base);
      end
    end
    return m;
  endfunction

  assign is_ckt  = fault_class_i[CLS_CIRCUIT];
  assign is_disc = is_ckt && (fault_blk_type_i == BLK_DISCRETE);
  assign is_ana  = is_ckt && (fault_blk_type_i == BLK_ANALOG);
  assign set_mask = (fault_valid_i && (is_ckt || fault_class_i[CLS_LOST])) ?
                    point_mask(fault_ref_i, fault_blk_cnt_i, fault_class_i[CLS_LOST],
                               is_ana, fault_ckt_num_i, status6_i) : '0; // R21

  // whole record loaded in the same edge so no reader sees a mixed record
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_reference_word      <= 16'h0000;
      fault_circuit_number_word <= 16'h0000;
      fault_status_copy_word    <= 16'h0000;
      fault_class_word          <= 16'h0000;
      fault_detail_word         <= 16'h0000;
      fault_circuit_kind_word   <= 16'h0000;
      fault_time_seconds_word   <= 16'h0000;
      fault_time_hours_word     <= 16'h0000;
      fault_time_days_word      <= 16'h0000;
    end else if (fault_valid_i) begin // R26
      fault_reference_word <= {4'h0, fault_out_ckt_i, fault_in_ckt_i, fault_ref_i}; // R25
      fault_circuit_number_word <= {(is_ckt ? {4'h0, fault_ckt_num_i} : 8'h00), 8'h00}; // R1
      fault_status_copy_word <= {status5_i, status4_i}; // R2
      fault_class_word <= {1'b0, fault_class_i, status6_i}; // R3 R2
      fault_detail_word <= {(is_disc ? {2'b00, status6_i[DISC_DET_W-1:0]} : 8'h00), // R5
                            (is_ckt ? {4'h0, fault_blk_type_i} : 8'h00)}; // R4
      fault_circuit_kind_word <= {14'h0000, is_ana, is_disc}; // R6
      fault_time_seconds_word <= {tm.sec, tm.tenths}; // R7
      fault_time_hours_word   <= {tm.hr, tm.min};
      fault_time_days_word    <= {tm.hund, tm.days};
    end
  end

  // command words; only four command bytes exist, so the reserved bytes have no storage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd     <= 16'h0000;
      cmd_ref <= 16'h0000;
    end else if (reg_we_i) begin // R9
      if (reg_addr_i == A_CMD) cmd <= reg_wdata_i & 16'h010F;
      else if (reg_addr_i == A_CMD_REF) cmd_ref <= reg_wdata_i;
    end
  end

  assign send_enable_o      = ~cmd[CMD_DIS_OUT]; // R10
  assign circuit_is_input_o = cmd[CMD_CKT_IN]; // R20

  // clear-all fires once per off-to-on change of the bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_clr_all <= 1'b0;
      clear_all_o  <= 1'b0;
    end else begin
      prev_clr_all <= cmd[CMD_CLR_ALL];
      clear_all_o  <= cmd[CMD_CLR_ALL] & ~prev_clr_all; // R12
    end
  end

  // clear-circuit waits for the next scan so at most one circuit goes per scan
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_clr_ckt    <= 1'b0;
      clr_ckt_armed   <= 1'b0;
      clear_circuit_o <= 1'b0;
      clear_ref_o     <= 10'h000;
    end else begin
      prev_clr_ckt    <= cmd[CMD_CLR_CKT];
      clear_circuit_o <= 1'b0;
      if (clr_ckt_armed && scan_tick_i) begin // R13
        clear_circuit_o <= 1'b1;
        clear_ref_o     <= cmd_ref[9:0];
        clr_ckt_armed   <= 1'b0;
      end
      if (cmd[CMD_CLR_CKT] && !prev_clr_ckt) clr_ckt_armed <= 1'b1; // R15
    end
  end

  // analog circuit index from the offset to the block's first reference
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      analog_sel_valid_o <= 1'b0;
      analog_sel_o       <= 3'h0;
    end else begin
      analog_sel_valid_o <= (cmd_ref[9:0] >= sel_blk_start_i) &&
                            ((cmd_ref[9:0] - sel_blk_start_i) < 10'(ANA_CKTS)); // R14
      analog_sel_o       <= 3'(cmd_ref[9:0] - sel_blk_start_i);
    end
  end

  // a one-scan test request is latched; the set wins over the clear at start
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      test_req <= 1'b0;
    end else if (reg_we_i && reg_addr_i == A_CMD && reg_wdata_i[CMD_PTEST]) begin
      test_req <= 1'b1; // R16
    end else if (tstate == T_IDLE) begin
      test_req <= 1'b0;
    end
  end

  // pulse test walk; idle lasts one cycle between tests so active toggles
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tstate       <= T_IDLE;
      test_dev_o   <= 5'h00;
      test_start_o <= 1'b0;
    end else begin
      test_start_o <= 1'b0;
      case (tstate)
        T_IDLE: begin
          if (test_req || cmd[CMD_PTEST]) begin // R18 R24
            tstate     <= T_SCAN;
            test_dev_o <= 5'h00;
          end
        end
        T_SCAN: begin
          if (test_eligible_i[test_dev_o]) begin // R16
            tstate       <= T_WAIT;
            test_start_o <= 1'b1;
          end else if (test_dev_o == LAST_DEV) begin
            tstate <= T_IDLE;
          end else begin
            test_dev_o <= test_dev_o + 5'h01; // R17
          end
        end
        T_WAIT: begin
          if (test_done_i) begin
            if (test_dev_o == LAST_DEV) begin
              tstate <= T_IDLE; // R18
            end else begin
              tstate     <= T_SCAN;
              test_dev_o <= test_dev_o + 5'h01; // R17
            end
          end
        end
        default: tstate <= T_IDLE;
      endcase
    end
  end

  assign test_active_o = (tstate != T_IDLE); // R24

  // point bits: a software write replaces a word, a fault in the same cycle still sets
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      point_status_o <= '0;
    end else begin
      for (int w = 0; w < NWORDS; w++) begin
        if (reg_we_i && reg_addr_i == A_PSTAT + 8'(w)) begin // R22
          point_status_o[w*16 +: 16] <= reg_wdata_i | set_mask[w*16 +: 16];
        end else begin
          point_status_o[w*16 +: 16] <= point_status_o[w*16 +: 16] | set_mask[w*16 +: 16];
        end
      end
    end
  end

  // software loads real time into the master clock
  assign tm.set_en   = reg_we_i && (reg_addr_i >= A_CLK_SEC) && (reg_addr_i <= A_CLK_DAY);
  assign tm.set_sel  = 2'(reg_addr_i - A_CLK_SEC);
  assign tm.set_data = reg_wdata_i;

  // read mux; unmapped offsets return zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      if (reg_addr_i == A_FAULT_REF) reg_rdata_o <= fault_reference_word;
      else if (reg_addr_i == A_FAULT_CKT) reg_rdata_o <= fault_circuit_number_word;
      else if (reg_addr_i == A_FAULT_STS) reg_rdata_o <= fault_status_copy_word;
      else if (reg_addr_i == A_FAULT_CLS) reg_rdata_o <= fault_class_word;
      else if (reg_addr_i == A_FAULT_DET) reg_rdata_o <= fault_detail_word;
      else if (reg_addr_i == A_FAULT_KIND) reg_rdata_o <= fault_circuit_kind_word;
      else if (reg_addr_i == A_FAULT_SEC) reg_rdata_o <= fault_time_seconds_word;
      else if (reg_addr_i == A_FAULT_HR) reg_rdata_o <= fault_time_hours_word;
      else if (reg_addr_i == A_FAULT_DAY) reg_rdata_o <= fault_time_days_word;
      else if (reg_addr_i == A_CMD) reg_rdata_o <= cmd;
      else if (reg_addr_i == A_CMD_REF) reg_rdata_o <= cmd_ref;
      else if (reg_addr_i == A_STATUS) reg_rdata_o <= {11'h000, test_dev_o} | 16'(test_active_o) << 8;
      else if (reg_addr_i == A_CLK_SEC) reg_rdata_o <= {tm.sec, tm.tenths};
      else if (reg_addr_i == A_CLK_HR) reg_rdata_o <= {tm.hr, tm.min};
      else if (reg_addr_i == A_CLK_DAY) reg_rdata_o <= {tm.hund, tm.days};
      else if (reg_addr_i >= A_PSTAT && reg_addr_i < A_PSTAT + 8'(NWORDS))
        reg_rdata_o <= point_status_o[int'(reg_addr_i - A_PSTAT)*16 +: 16];
      else reg_rdata_o <= 16'h0000;
    end
  end

  // checks on record contents and command sequencing
  ckt_num_zero_a: assert property (fault_valid_i && !fault_class_i[CLS_CIRCUIT] |=> // R1
    fault_circuit_number_word == 16'h0000) else $error("circuit number not zero");
  class_top_a: assert property (fault_valid_i |=> !fault_class_word[15] && // R3
    fault_class_word[14:8] == $past(fault_class_i)) else $error("class byte wrong");
  kind_upper_a: assert property (fault_valid_i |=> fault_circuit_kind_word[15:8] == 8'h00 && // R6
    fault_circuit_kind_word[W7_DISC] == $past(is_disc)) else $error("kind word wrong");
  stamp_time_a: assert property (fault_valid_i |=> // R7
    fault_time_seconds_word == $past({tm.sec, tm.tenths})) else $error("timestamp mismatch");
  clear_all_once_a: assert property ($rose(cmd[CMD_CLR_ALL]) |=> clear_all_o ##1 !clear_all_o) // R12
    else $error("clear all pulse wrong");
  clear_ckt_scan_a: assert property (clear_circuit_o |-> $past(scan_tick_i) && // R13
    !$past(clear_circuit_o)) else $error("circuit clear off scan");
  test_start_a: assert property (tstate == T_IDLE && cmd[CMD_PTEST] |=> // R24
    test_active_o && test_dev_o == 5'h00) else $error("test did not start");
  dev_advance_a: assert property (tstate == T_WAIT && test_done_i && test_dev_o != LAST_DEV |=> // R17
    test_dev_o == $past(test_dev_o) + 5'h01) else $error("device walk wrong");
  point_sticky_a: assert property (point_status_o[0] && !(reg_we_i && reg_addr_i == A_PSTAT) |=> // R22
    point_status_o[0]) else $error("point bit lost");

  // record fields, point marking and the end of a test walk
  status_copy_a: assert property (fault_valid_i |=> // R2
    fault_status_copy_word == $past({status5_i, status4_i}))
    else $error("status copy wrong");
  type_low_a: assert property (fault_valid_i |=> // R4
    fault_detail_word[7:4] == 4'h0)
    else $error("type byte wrong");
  disc_detail_a: assert property (fault_valid_i && is_disc |=> // R5
    fault_detail_word[15:8] == {2'b00, $past(status6_i[DISC_DET_W-1:0])})
    else $error("detail byte wrong");
  ref_flags_a: assert property (fault_valid_i |=> // R25
    fault_reference_word[11:10] == $past({fault_out_ckt_i, fault_in_ckt_i}))
    else $error("circuit flags wrong");
  point_set_a: assert property (set_mask != '0 |=> // R21
    (point_status_o & $past(set_mask)) == $past(set_mask))
    else $error("point bit not set");
  test_end_a: assert property (tstate == T_WAIT && test_done_i && // R18
    test_dev_o == LAST_DEV |=> !test_active_o) else $error("test did not end");
endmodule // io_bus_fault_diag

// ===== iobd_bus_model.sv
// Purpose: far-side bus controller stand-in for pulse test handshakes
// Assumes: one clock, test_start_i is a one-cycle pulse
// Notes:   done answers after a set delay; blocks fall back after silence
`timescale 1ns/1ps
module iobd_bus_model #(
  parameter int DONE_DELAY  = 3,
  parameter int HOLD_CYCLES = 50
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic send_enable_i,
  input  wire logic test_start_i,
  output logic      test_done_o,
  output logic      outputs_failed_o
);
  int done_cnt;
  int quiet_cnt;
  // a block reports completion some cycles after its start, never at once
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_cnt    <= 0;
      test_done_o <= 1'b0;
    end else begin
      test_done_o <= (done_cnt == 1);
      if (test_start_i) begin
        done_cnt <= DONE_DELAY;
      end else if (done_cnt > 0) begin
        done_cnt <= done_cnt - 1;
      end
    end
  end
  // blocks hold outputs while no data comes, then assume the bus failed
  always_ff @(posedge clk_i) begin
    if (reset_i || send_enable_i) begin
      quiet_cnt        <= 0;
      outputs_failed_o <= 1'b0;
    end else begin
      if (quiet_cnt < HOLD_CYCLES) quiet_cnt <= quiet_cnt + 1;
      outputs_failed_o <= (quiet_cnt >= HOLD_CYCLES - 1);
    end
  end
endmodule // iobd_bus_model

// ===== io_bus_fault_diag_bench.sv
// Purpose: self-checking bench for the bus fault diagnostic block
// Assumes: TICK shortened to 10 cycles, far side modelled separately
// Notes:   outputs are sampled 1 ns after the edge so updates have landed
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module io_bus_fault_diag_bench;
  import iobd_pkg::*;
  logic clk_i = 0, reset_i = 1, we = 0, re = 0, pwr = 1, scan = 0, fv = 0, fin = 0, fout = 0;
  logic [7:0] addr = 0, blk_cnt = 0, s4 = 0, s5 = 0, s6 = 0;
  logic [15:0] wdata = 0, rdata, d;
  logic [6:0] cls = 0;
  logic [3:0] ckt = 0, btype = 0;
  logic [9:0] fref = 0, blk_start = 0, clear_ref;
  logic [31:0] eligible = 32'h8000_0001;
  logic done, send_en, clear_all, clear_ckt, is_in, ana_v, active, tstart, failed;
  logic [2:0] ana_sel;
  logic [4:0] tdev;
  logic [63:0] pstat;
  logic [4:0] starts[$];
  int miscompares = 0, total_checks = 0, cycles = 0, pa, pc;
  io_bus_fault_diag #(.NPTS(64), .TICK(10)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .power_ok_i(pwr), .scan_tick_i(scan), .fault_valid_i(fv),
    .fault_class_i(cls), .fault_ckt_num_i(ckt), .fault_ref_i(fref),
    .fault_blk_cnt_i(blk_cnt), .fault_in_ckt_i(fin), .fault_out_ckt_i(fout),
    .fault_blk_type_i(btype), .status4_i(s4), .status5_i(s5), .status6_i(s6),
    .sel_blk_start_i(blk_start), .test_eligible_i(eligible), .test_done_i(done),
    .send_enable_o(send_en), .clear_all_o(clear_all), .clear_circuit_o(clear_ckt),
    .clear_ref_o(clear_ref), .circuit_is_input_o(is_in), .analog_sel_valid_o(ana_v),
    .analog_sel_o(ana_sel), .test_active_o(active), .test_start_o(tstart),
    .test_dev_o(tdev), .point_status_o(pstat));
  iobd_bus_model #(.DONE_DELAY(3), .HOLD_CYCLES(50)) far (.clk_i(clk_i),
    .reset_i(reset_i), .send_enable_i(send_en), .test_start_i(tstart),
    .test_done_o(done), .outputs_failed_o(failed));
  always #50 clk_i = ~clk_i;
  // hang guard: the whole run needs well under 5000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr <= a; wdata <= v; we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a; re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  // count one-cycle pulses over n cycles, starting in the current cycle
  task automatic watch(input int n);
    pa = 0; pc = 0;
    repeat (n) begin
      #1;
      pa += (clear_all === 1'b1);
      pc += (clear_ckt === 1'b1);
      if (clear_ckt === 1'b1) d = {6'h00, clear_ref};
      @(posedge clk_i);
    end
  endtask
  task automatic fault(input logic [6:0] c, input logic [9:0] r, input logic [7:0] n);
    @(posedge clk_i);
    fv <= 1'b1; cls <= c; fref <= r; blk_cnt <= n;
    @(posedge clk_i);
    fv <= 1'b0;
  endtask
  task automatic t_commands();
    #1 `CHK({send_en, active, pstat}, {1'b1, 1'b0, 64'h0})
    wr(A_CMD, 16'h0001); #1 `CHK(send_en, 1'b0)
    repeat (52) @(posedge clk_i); #1 `CHK(failed, 1'b1)
    wr(A_CMD, 16'h0000); #1 `CHK(send_en, 1'b1)
    wr(A_CMD, 16'h0002); watch(4); `CHK(pa, 1)
    wr(A_CMD, 16'h0002); watch(4); `CHK(pa, 0)
    wr(A_CMD, 16'h0100); watch(2); `CHK(is_in, 1'b1)
    wr(A_CMD, 16'h0000); watch(2); `CHK(is_in, 1'b0)
    $display("test commands done");
  endtask
  task automatic t_clear_circuit();
    blk_start <= 10'd3;
    wr(A_CMD_REF, 16'h0007); wr(A_CMD, 16'h0004); watch(3);
    `CHK({ana_v, ana_sel}, {1'b1, 3'd4})
    `CHK(pc, 0)
    @(posedge clk_i); scan <= 1'b1; @(posedge clk_i); scan <= 1'b0;
    watch(4); `CHK(pc, 1) `CHK(d, 16'h0007)
    @(posedge clk_i); scan <= 1'b1; @(posedge clk_i); scan <= 1'b0;
    watch(4); `CHK(pc, 0)
    wr(A_CMD_REF, 16'h0009); wr(A_CMD, 16'h0000); wr(A_CMD, 16'h0004);
    @(posedge clk_i); scan <= 1'b1; @(posedge clk_i); scan <= 1'b0;
    watch(4); `CHK(pc, 1) `CHK(d, 16'h0009) `CHK(ana_v, 1'b0)
    wr(A_CMD, 16'h0000);
    $display("test clear circuit done");
  endtask
  task automatic t_faults();
    pwr <= 1'b0; ckt <= 4'd5; btype <= BLK_DISCRETE; fout <= 1'b1;
    s4 <= 8'h11; s5 <= 8'h22; s6 <= 8'h3F;
    wr(A_CLK_SEC, 16'h0305);
    fault(7'h04, 10'd10, 8'd0);
    rd(A_FAULT_REF); `CHK(d, 16'h080A)
    rd(A_FAULT_CKT); `CHK(d, 16'h0500)
    rd(A_FAULT_STS); `CHK(d, 16'h2211)
    rd(A_FAULT_CLS); `CHK(d, 16'h043F)
    rd(A_FAULT_DET); `CHK(d, 16'h3F01)
    rd(A_FAULT_KIND); `CHK(d, 16'h0001)
    rd(A_FAULT_SEC); `CHK(d, 16'h0305)
    rd(A_PSTAT); `CHK(d, 16'h0200)
    wr(A_FAULT_CKT, 16'hFFFF); rd(A_FAULT_CKT); `CHK(d, 16'h0500)
    rd(8'h30); `CHK(d, 16'h0000)
    repeat (30) @(posedge clk_i);
    rd(A_CLK_SEC); `CHK(d, 16'h0305)
    s6 <= 8'h00;
    fault(7'h08, 10'd17, 8'd8);
    rd(A_FAULT_CKT); `CHK(d, 16'h0000)
    rd(A_FAULT_CLS); `CHK(d, 16'h0800)
    rd(A_FAULT_DET); `CHK(d[7:4], 4'h0)
    rd(A_FAULT_KIND); `CHK(d, 16'h0000)
    rd(A_PSTAT + 8'h01); `CHK(d, 16'h00FF)
    wr(A_PSTAT, 16'h0000); rd(A_PSTAT); `CHK(d, 16'h0000)
    rd(A_PSTAT + 8'h01); `CHK(d, 16'h00FF)
    btype <= BLK_ANALOG; ckt <= 4'd1; s6 <= 8'h15;
    fault(7'h04, 10'd33, 8'd0);
    rd(A_FAULT_KIND); `CHK(d, 16'h0002)
    rd(A_FAULT_DET); `CHK(d, 16'h0002)
    rd(A_PSTAT + 8'h02); `CHK(d, 16'h0540)
    pwr <= 1'b1; repeat (25) @(posedge clk_i);
    rd(A_CLK_SEC); `CHK(d[7:0] > 8'h05 && d[7:0] < 8'h09, 1'b1)
    $display("test faults done");
  endtask
  task automatic t_pulse_test();
    wr(A_CMD, 16'h0008); wr(A_CMD, 16'h0000);
    #1 `CHK(active, 1'b1)
    for (int i = 0; i < 400 && active === 1'b1; i++) begin
      if (tstart === 1'b1) starts.push_back(tdev);
      @(posedge clk_i); #1;
    end
    `CHK(starts.size(), 2)
    `CHK({starts[0], starts[1]}, {5'd0, 5'd31})
    `CHK(active, 1'b0)
    wr(A_CMD, 16'h0008); @(posedge clk_i); #1 `CHK(active, 1'b1)
    for (int i = 0; i < 400 && active !== 1'b0; i++) begin
      @(posedge clk_i); #1;
    end
    `CHK(active, 1'b0)
    @(posedge clk_i); #1 `CHK(active, 1'b1)
    wr(A_CMD, 16'h0000);
    for (int i = 0; i < 400 && active !== 1'b0; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i); #1 `CHK(active, 1'b0)
    $display("test pulse test done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_commands();
    t_clear_circuit();
    t_faults();
    t_pulse_test();
    complete_run();
  end
endmodule // io_bus_fault_diag_bench
